// ### sim/sfma_mem_model.sv
// Purpose: Memory side of the burst address port
// Assumes: Accepts every beat at once
// Notes:   Records beat count and last address
`timescale 1ns/100ps

module sfma_mem_model (
    input  wire logic        clk_i,
    input  wire logic [31:0] data_addr_i,
    input  wire logic        data_valid_i,
    output int               beats_o,
    output logic      [31:0] last_addr_o
);
    int n_beats = 0;
    assign beats_o = n_beats;
    // Address used as is: no translation stage
    always @(posedge clk_i) begin
        if (data_valid_i) begin
            n_beats     <= n_beats + 1;
            last_addr_o <= data_addr_i;
        end
    end
endmodule // sfma_mem_model

// ### sim/tb_top.sv
// Purpose: Self-checking bench of the status/mode/address core
// Assumes: No coprocessors present
// Notes:   Table of flag cases, then hand tests
`timescale 1ns/100ps

module tb_top import sfma_pkg::*;;
    typedef struct packed {sfma_op_e op; logic [31:0] a, b; logic cin; logic [4:0] fl; logic [31:0] r;} sfma_row_s;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, busy, hm, pv, dv, dbg;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, rd, res, fa, da, exp_pc, la;
    logic [4:0] fl;
    sfma_instr_s ins = '0;
    sfma_exc_s exc;
    int errors = 0, n_compared = 0, cyc_n = 0, beats;
    localparam logic [31:0] RESET_PC_V = 32'h0000_0100;
    sfma_row_s rows [7] = '{'{OP_ADD, 32'h7FFF_FFFF, 32'h1, 1'b0, 5'h12, 32'h8000_0000},
        '{OP_ADD, 32'hFFFF_FFFF, 32'h1, 1'b0, 5'h0C, 32'h0}, '{OP_ADD, 32'h1, 32'h2, 1'b0, 5'h00, 32'h3},
        '{OP_LOGIC, 32'h8000_0000, 32'h0, 1'b0, 5'h10, 32'h8000_0000},
        '{OP_SIGNED_SATURATE_INSTR, 32'hFFFF_FF00, 32'h0, 1'b0, 5'h10, 32'hFFFF_FF00},
        '{OP_UNSIGNED_SATURATE_INSTR, 32'hFFFF_FFFF, 32'h0, 1'b0, 5'h11, 32'h0},
        '{OP_ADD, 32'h5, 32'hFFFF_FFFA, 1'b1, 5'h0D, 32'h0}};
    sfma_op_e eop [3] = '{OP_SVC, OP_COPROC, OP_UNDEF};
    sfma_cause_e ecs [3] = '{CAUSE_SVC, CAUSE_NO_COPROCESSOR_CAUSE, CAUSE_UNDEF};
    initial forever #5 clk_i = ~clk_i;
    sfma_core DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .instr_i(ins),
        .busy_o(busy), .flags_o(fl), .result_o(res), .fetch_addr_o(fa), .data_addr_o(da), .data_valid_o(dv),
        .handler_mode_o(hm), .privileged_o(pv), .exc_o(exc), .debug_event_o(dbg));
    sfma_mem_model MEM (.clk_i(clk_i), .data_addr_i(da), .data_valid_i(dv), .beats_o(beats), .last_addr_o(la));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i) {cyc, we, adr, wd} <= {1'b1, w, a, d};
        // Hold until the edge that samples ack high, take data there, then release
        do @(posedge clk_i); while (ack !== 1'b1 && cyc_n < 5000);
        rd = rdat;
        {cyc, we} <= 2'b00;
    endtask
    task automatic issue(input sfma_op_e op, input logic i32, input logic [31:0] a, b, input logic cin);
        @(posedge clk_i) ins <= '{1'b1, op, i32, 1'b1, cin, 4'h1, 1'b0, 5'h08, a, b};
        @(posedge clk_i) ins.valid <= 1'b0;
        #1;
    endtask
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n > 5000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("pc", fa, RESET_PC_V);
        chk("mode", {hm, pv}, 2'b01);
        exp_pc = RESET_PC_V;
        for (int i = 0; i < 7; i++) begin
            issue(rows[i].op, i[0], rows[i].a, rows[i].b, rows[i].cin);
            exp_pc = exp_pc + (i[0] ? 32'h4 : 32'h2);
            chk("flags", fl, rows[i].fl);
            chk("result", res, rows[i].r);
            chk("pc", fa, exp_pc);
        end
        wb(1'b0, OFF_STATUS, 32'h0);
        chk("status", rd, 32'h6800_0000);
        wb(1'b1, OFF_STATUS, 32'h0);
        wb(1'b0, OFF_STATUS, 32'h0);
        chk("status clr", rd, 32'h0);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", rd, 32'h0);
        for (int i = 0; i < 3; i++) begin
            issue(eop[i], 1'b0, 32'h0, 32'h0, 1'b0);
            chk("exc", exc, {1'b1, ecs[i]});
            chk("mode", {hm, pv}, 2'b11);
        end
        issue(OP_BREAKPOINT_INSTR, 1'b0, 32'h0, 32'h0, 1'b0);
        chk("debug", dbg, 1'b1);
        issue(OP_MULTI, 1'b0, 32'hFFFF_FFFC, 32'h2, 1'b0);
        chk("busy", busy, 1'b1);
        for (int k = 0; k < 20 && busy !== 1'b0; k++) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        chk("beats", beats, 2);
        chk("last", la, 32'h0);
        wb(1'b1, OFF_CTRL, 32'h0000_0001);
        wb(1'b0, OFF_CTRL, 32'h0);
        chk("ctrl", rd, 32'h0000_0001);
        issue(OP_EXC_RET, 1'b0, 32'h0, 32'h0, 1'b0);
        chk("mode", {hm, pv}, 2'b00);
        issue(OP_SVC, 1'b0, 32'h0, 32'h0, 1'b0);
        chk("exc", exc, {1'b1, CAUSE_SVC});
        chk("mode", {hm, pv}, 2'b11);
        wb(1'b0, OFF_STATE, 32'h0);
        chk("state", rd, 32'h0000_0703);
        wb(1'b1, OFF_STATE, 32'h0000_1F00);
        wb(1'b0, OFF_STATE, 32'h0);
        chk("state clr", rd, 32'h0000_0003);
        issue(OP_BRANCH, 1'b0, 32'hFFFF_F001, 32'h0, 1'b0);
        chk("branch", fa, 32'hFFFF_F000);
        issue(OP_ADD, 1'b0, 32'h0, 32'h0, 1'b0);
        chk("xn", exc, {1'b1, CAUSE_XN});
        chk("xn pc", fa, 32'hFFFF_F000);
        chk("xn flags", fl, 5'h00);
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("reset pc", fa, RESET_PC_V);
        chk("reset mode", {hm, pv, exc.valid}, 3'b010);
        give_verdict();
    end
endmodule // tb_top

// ### src/sfma_addr.sv
// Purpose: Instruction and multi-register address arithmetic
// Assumes: Addresses are physical byte addresses
// Notes:   All sums wrap at 32 bits
`timescale 1ns/100ps

module sfma_addr import sfma_pkg::*; #(
    parameter logic [31:0] XN_BASE = 32'hFFFF_F000
) (
    input  wire logic [31:0] pc_i,
    input  wire logic        is32_i,
    input  wire logic [31:0] base_i,
    input  wire logic [4:0]  beat_i,
    output logic      [31:0] pc_next_o,
    output logic      [31:0] beat_addr_o,
    output logic             in_xn_o
);
    // Carry out of bit 31 is dropped on purpose
    assign pc_next_o   = pc_i + (is32_i ? PC_STEP32 : PC_STEP16);
    // One word is four consecutive byte addresses
    assign beat_addr_o = base_i + WORD_STEP * {27'h0, beat_i};
    assign in_xn_o     = (pc_i >= XN_BASE);
endmodule // sfma_addr

// ### src/sfma_alu.sv
// Purpose: Add-with-carry and saturation datapath
// Assumes: Subtraction is fed as a plus inverted b with carry in
// Notes:   Purely combinational
`timescale 1ns/100ps

module sfma_alu import sfma_pkg::*; (
    input  wire sfma_op_e    op_i,
    input  wire logic [31:0] a_i,
    input  wire logic [31:0] b_i,
    input  wire logic        cin_i,
    input  wire logic [4:0]  sat_n_i,
    output logic      [31:0] res_o,
    output logic             carry_o,
    output logic             ovf_o,
    output logic             sat_o
);
    logic        [32:0] sum;
    logic signed [32:0] sa;
    logic signed [32:0] hi;
    logic signed [32:0] lo;

    always_comb begin
        sum     = {1'b0, a_i} + {1'b0, b_i} + {32'h0000_0000, cin_i};
        sa      = $signed({a_i[31], a_i});
        hi      = 33'sh0_0000_0000;
        lo      = 33'sh0_0000_0000;
        res_o   = sum[31:0];
        carry_o = sum[32];
        ovf_o   = (a_i[31] == b_i[31]) && (sum[31] != a_i[31]);
        sat_o   = 1'b0;
        if (op_i == OP_SIGNED_SATURATE_INSTR || op_i == OP_UNSIGNED_SATURATE_INSTR) begin
            // Signed width is sat_n+1, unsigned width is sat_n
            hi = (33'sh0_0000_0001 <<< sat_n_i) - 33'sh0_0000_0001;
            lo = (op_i == OP_SIGNED_SATURATE_INSTR) ? -(33'sh0_0000_0001 <<< sat_n_i) : 33'sh0_0000_0000;
            res_o = a_i;
            if (sa > hi) begin
                res_o = hi[31:0];
                sat_o = 1'b1;
            end else if (sa < lo) begin
                res_o = lo[31:0];
                sat_o = 1'b1;
            end
        end
    end
endmodule // sfma_alu

// ### src/sfma_core.sv
// Purpose: Status flags, execution mode, fault generation and addressing
// Assumes: Instructions arrive one per cycle from same-clock decode logic
// Notes:   Registers on a classic Wishbone slave, one wait state
`timescale 1ns/100ps

module sfma_core import sfma_pkg::*; #(
    parameter logic [31:0] RESET_PC   = 32'h0000_0100,
    parameter logic [31:0] XN_BASE    = 32'hFFFF_F000,
    parameter logic [7:0]  CP_PRESENT = 8'h00
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire sfma_instr_s instr_i,
    output logic             busy_o,
    output logic      [4:0]  flags_o,
    output logic      [31:0] result_o,
    output logic      [31:0] fetch_addr_o,
    output logic      [31:0] data_addr_o,
    output logic             data_valid_o,
    output logic             handler_mode_o,
    output logic             privileged_o,
    output sfma_exc_s        exc_o,
    output logic             debug_event_o
);
    // ************************************************************
    // State
    // ************************************************************
    logic        [4:0]  flags_q;
    logic               unpriv_q;
    logic               dbgmon_q;
    logic        [7:0]  cpen_q;
    sfma_mode_e         mode_q;
    logic               priv_q;
    logic [NUM_CAUSE-1:0] sticky_q;
    logic        [31:0] pc_q;
    logic               busy_q;
    logic        [4:0]  beat_q;
    logic        [4:0]  cnt_q;
    logic        [31:0] base_q;
    logic        [31:0] data_addr_q;
    logic               data_valid_q;
    sfma_exc_s          exc_q;
    logic               dbg_ev_q;
    logic        [31:0] result_q;
    logic               ack_q;
    logic        [31:0] rd_q;

    logic        [31:0] alu_res;
    logic               alu_c;
    logic               alu_v;
    logic               alu_sat;
    logic        [31:0] pc_next;
    logic        [31:0] beat_addr;
    logic               in_xn;
    logic               accept;
    logic               cp_ok;
    logic               wr_en;
    sfma_cause_e        cause_d;
    logic               dbg_d;
    logic        [31:0] rd_d;

    // ************************************************************
    // Datapath leaves
    // ************************************************************
    sfma_alu u_alu (
        .op_i    (instr_i.op),
        .a_i     (instr_i.a),
        .b_i     (instr_i.b),
        .cin_i   (instr_i.cin),
        .sat_n_i (instr_i.sat_n),
        .res_o   (alu_res),
        .carry_o (alu_c),
        .ovf_o   (alu_v),
        .sat_o   (alu_sat)
    );

    sfma_addr #(
        .XN_BASE (XN_BASE)
    ) u_addr (
        .pc_i        (pc_q),
        .is32_i      (instr_i.is32),
        .base_i      (base_q),
        .beat_i      (beat_q),
        .pc_next_o   (pc_next),
        .beat_addr_o (beat_addr),
        .in_xn_o     (in_xn)
    );

    // ************************************************************
    // Fault decode
    // ************************************************************
    // New instructions are held off while a multi-register burst runs
    assign accept = instr_i.valid && !busy_q;
    // Reserved numbers and units left out by CP_PRESENT never answer
    assign cp_ok  = (instr_i.cp_num < CP_RSVD_LO) && CP_PRESENT[instr_i.cp_num[2:0]]
                    && cpen_q[instr_i.cp_num[2:0]];

    always_comb begin
        cause_d = CAUSE_NONE;
        dbg_d   = 1'b0;
        if (accept) begin
            if (in_xn) begin
                cause_d = CAUSE_XN;
            end else begin
                case (instr_i.op)
                    OP_SVC: begin
                        cause_d = CAUSE_SVC;
                    end
                    OP_UNDEF: begin
                        cause_d = CAUSE_UNDEF;
                    end
                    OP_COPROC: begin
                        if (!cp_ok) begin
                            cause_d = CAUSE_NO_COPROCESSOR_CAUSE;
                        end else if (!instr_i.cp_known) begin
                            cause_d = CAUSE_UNDEF;
                        end
                    end
                    OP_BREAKPOINT_INSTR: begin
                        dbg_d = 1'b1;
                        if (dbgmon_q) begin
                            cause_d = CAUSE_DBGMON;
                        end
                    end
                    default: begin
                        cause_d = CAUSE_NONE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exc_q    <= '{valid: 1'b0, cause: CAUSE_NONE};
            dbg_ev_q <= 1'b0;
        end else if (ce_i) begin
            exc_q    <= '{valid: (cause_d != CAUSE_NONE), cause: cause_d};
            dbg_ev_q <= dbg_d;
        end
    end

    // ************************************************************
    // Mode and privilege
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= MODE_THREAD;
            priv_q <= !RST_UNPRIV;
        end else if (ce_i) begin
            if (cause_d != CAUSE_NONE) begin
                mode_q <= MODE_HANDLER;
                priv_q <= 1'b1;
            end else if (accept && instr_i.op == OP_EXC_RET && mode_q == MODE_HANDLER) begin
                mode_q <= MODE_THREAD;
                priv_q <= !unpriv_q;
            end else if (mode_q == MODE_THREAD) begin
                priv_q <= !unpriv_q;
            end
        end
    end

    // ************************************************************
    // Flags
    // ************************************************************
    // Software write first, hardware update after, so hardware wins a tie
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= RST_FLAGS;
        end else if (ce_i) begin
            if (wr_en && wb_adr_i == OFF_STATUS && wb_sel_i[3]) begin
                flags_q <= wb_dat_i[31:FLAGS_LO];
            end
            if (accept && cause_d == CAUSE_NONE && instr_i.set_flags) begin
                if (instr_i.op == OP_ADD || instr_i.op == OP_LOGIC) begin
                    flags_q[FI_N] <= alu_res[31];
                    flags_q[FI_Z] <= (alu_res == 32'h0000_0000);
                    flags_q[FI_C] <= (instr_i.op == OP_ADD) ? alu_c : instr_i.cin;
                end
                if (instr_i.op == OP_ADD) begin
                    flags_q[FI_V] <= alu_v;
                end
            end
            if (accept && cause_d == CAUSE_NONE && alu_sat) begin
                flags_q[FI_Q] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q <= 32'h0000_0000;
        end else if (ce_i && accept && cause_d == CAUSE_NONE) begin
            result_q <= alu_res;
        end
    end

    // ************************************************************
    // Program counter and multi-register burst
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_q <= RESET_PC;
        end else if (ce_i && accept && cause_d == CAUSE_NONE) begin
            if (instr_i.op == OP_BRANCH) begin
                pc_q <= {instr_i.a[31:1], 1'b0};
            end else begin
                pc_q <= pc_next;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q       <= 1'b0;
            beat_q       <= 5'h00;
            cnt_q        <= 5'h00;
            base_q       <= 32'h0000_0000;
            data_addr_q  <= 32'h0000_0000;
            data_valid_q <= 1'b0;
        end else if (ce_i) begin
            data_valid_q <= busy_q;
            if (busy_q) begin
                // Address leaves untranslated; data may keep its low bits
                data_addr_q <= beat_addr;
                beat_q      <= beat_q + 5'h01;
                busy_q      <= (beat_q != cnt_q);
            end else if (accept && cause_d == CAUSE_NONE && instr_i.op == OP_MULTI
                         && instr_i.b[4:0] != 5'h00) begin
                busy_q <= 1'b1;
                beat_q <= 5'h00;
                cnt_q  <= instr_i.b[4:0] - 5'h01;
                base_q <= instr_i.a;
            end
        end
    end

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    // Write lands on the edge where the master sees ack
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

    always_comb begin
        case (wb_adr_i)
            OFF_STATUS: rd_d = {flags_q, 27'h000_0000};
            OFF_CTRL:   rd_d = {16'h0000, cpen_q, 6'h00, dbgmon_q, unpriv_q};
            OFF_STATE:  rd_d = {19'h0_0000, sticky_q, 5'h00, busy_q, priv_q, mode_q};
            OFF_PC:     rd_d = pc_q;
            default:    rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rd_q  <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            rd_q  <= rd_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unpriv_q <= RST_UNPRIV;
            dbgmon_q <= RST_DBGMON;
            cpen_q   <= RST_CPEN;
        end else if (ce_i && wr_en && wb_adr_i == OFF_CTRL) begin
            if (wb_sel_i[0]) begin
                unpriv_q <= wb_dat_i[CTRL_UNPRIV_BIT];
                dbgmon_q <= wb_dat_i[CTRL_DBGMON_BIT];
            end
            if (wb_sel_i[1]) begin
                cpen_q <= wb_dat_i[CTRL_CPEN_LO +: 8];
            end
        end
    end

    // Cause history, write one to clear, a new cause wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sticky_q <= '0;
        end else if (ce_i) begin
            for (int i = 0; i < NUM_CAUSE; i++) begin
                if (cause_d == sfma_cause_e'(i + 1)) begin
                    sticky_q[i] <= 1'b1;
                end else if (wr_en && wb_adr_i == OFF_STATE && wb_sel_i[1]
                             && wb_dat_i[STICKY_LO + i]) begin
                    sticky_q[i] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign wb_dat_o       = rd_q;
    assign wb_ack_o       = ack_q;
    assign busy_o         = busy_q;
    assign flags_o        = flags_q;
    assign result_o       = result_q;
    assign fetch_addr_o   = pc_q;
    assign data_addr_o    = data_addr_q;
    assign data_valid_o   = data_valid_q;
    assign handler_mode_o = (mode_q == MODE_HANDLER);
    assign privileged_o   = priv_q;
    assign exc_o          = exc_q;
    assign debug_event_o  = dbg_ev_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic flag_ok;
    assign flag_ok = ce_i && accept && cause_d == CAUSE_NONE && instr_i.set_flags
                     && instr_i.op == OP_ADD;

    a_neg_flag: assert property (flag_ok |=> flags_q[FI_N] == $past(alu_res[31]))
        else $error("negative flag mismatch");
    a_zero_flag: assert property (flag_ok |=> flags_q[FI_Z] == ($past(alu_res) == 32'h0))
        else $error("zero flag mismatch");
    a_carry_ovf: assert property (flag_ok |=> flags_q[FI_C] == $past(alu_c)
                                  && flags_q[FI_V] == $past(alu_v))
        else $error("carry or overflow flag mismatch");
    a_sat_sticky: assert property (ce_i && accept && !in_xn && alu_sat |=> flags_q[FI_Q])
        else $error("saturation flag not set");
    a_handler_priv: assert property (mode_q == MODE_HANDLER |-> priv_q)
        else $error("handler mode without privilege");
    a_svc_raise: assert property (ce_i && accept && !in_xn && instr_i.op == OP_SVC
                                  |=> exc_q.valid && exc_q.cause == CAUSE_SVC && mode_q == MODE_HANDLER)
        else $error("supervisor call not raised");
    a_no_coprocessor_cause_fault: assert property (ce_i && accept && !in_xn && instr_i.op == OP_COPROC && !cp_ok
                                   |=> exc_q.cause == CAUSE_NO_COPROCESSOR_CAUSE)
        else $error("missing no-coprocessor fault");
    a_breakpoint_instr_event: assert property (ce_i && accept && !in_xn && instr_i.op == OP_BREAKPOINT_INSTR
                                   |=> dbg_ev_q)
        else $error("breakpoint without debug event");
    a_seq_pc: assert property (ce_i && accept && cause_d == CAUSE_NONE && instr_i.op == OP_ADD
                               |=> pc_q == $past(pc_q) + ($past(instr_i.is32) ? 32'h4 : 32'h2))
        else $error("sequential address step wrong");
    a_multi_step: assert property (ce_i && busy_q && data_valid_q
                                   |=> data_addr_q == $past(data_addr_q) + 32'h4)
        else $error("burst address step wrong");
    a_reset_thread: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> mode_q == MODE_THREAD)
        else $error("reset did not select thread mode");

    c_svc_taken: cover property (exc_q.valid && exc_q.cause == CAUSE_SVC);
    c_no_coprocessor_cause_taken: cover property (exc_q.valid && exc_q.cause == CAUSE_NO_COPROCESSOR_CAUSE);
    c_burst_done: cover property (data_valid_q && !busy_q);
    c_sat_set: cover property (!flags_q[FI_Q] ##1 flags_q[FI_Q]);

endmodule // sfma_core

// ### src/sfma_pkg.sv
// Purpose: Shared constants, types and carriers of the status/mode/address core
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes:   Register offsets are byte addresses on a classic Wishbone slave
//
// How it works
// - Negative flag takes bit 31 of a flag-setting result.
// - Zero flag is 1 for an all-zero result, else 0.
// - Carry flag is 1 when the instruction produces a carry.
// - Overflow flag is 1 when the instruction produces a signed overflow.
// - Saturation flag sticks at 1 when a saturate instruction clamps.
// - Status word low reserved bits read unknown; software preserves them.
// - Reset enters thread mode, privileged or not per configuration.
// - Every exception runs in handler mode with privilege.
// - Supervisor call instruction raises its exception from thread mode.
// - Coprocessors 8 to 15 reserved; absent support means none exist.
// - Coprocessor instruction to absent or disabled unit: no-coprocessor usage fault.
// - Unknown instruction to enabled coprocessor: undefined-instruction usage fault.
// - Undefined encoding raises a synchronous usage fault.
// - Breakpoint gives a debug event, which may raise the monitor exception.
// - Addresses are unsigned 32-bit byte addresses in one flat space.
// - Word is aligned on multiples of four and spans four bytes.
// - Halfword is aligned on multiples of two and spans two bytes.
// - Fetches are halfword aligned; data may carry low address bits.
// - Address arithmetic wraps modulo two to the thirty-second.
// - Sequential next address is current plus 2 or plus 4.
// - Top of memory is execute-never; fetching there reports a violation.
// - Multi-register transfers step the address by four per register.
// - Add carry is 0 when the unsigned sum fits, else 1.
// - Add overflow is 0 when the signed sum fits, else 1.

package sfma_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  OFF_STATUS      = 8'h00;
    localparam logic [7:0]  OFF_CTRL        = 8'h04;
    localparam logic [7:0]  OFF_STATE       = 8'h08;
    localparam logic [7:0]  OFF_PC          = 8'h0C;

    localparam int unsigned FLAGS_LO        = 27;
    localparam int unsigned FI_N            = 4;
    localparam int unsigned FI_Z            = 3;
    localparam int unsigned FI_C            = 2;
    localparam int unsigned FI_V            = 1;
    localparam int unsigned FI_Q            = 0;
    localparam int unsigned CTRL_UNPRIV_BIT = 0;
    localparam int unsigned CTRL_DBGMON_BIT = 1;
    localparam int unsigned CTRL_CPEN_LO    = 8;
    localparam int unsigned STATE_MODE_BIT  = 0;
    localparam int unsigned STATE_PRIV_BIT  = 1;
    localparam int unsigned STATE_BUSY_BIT  = 2;
    localparam int unsigned STICKY_LO       = 8;

    localparam logic [4:0]  RST_FLAGS       = 5'h00;
    localparam logic [7:0]  RST_CPEN        = 8'h00;
    localparam logic        RST_UNPRIV      = 1'b0;
    localparam logic        RST_DBGMON      = 1'b0;

    localparam logic [31:0] PC_STEP16       = 32'h0000_0002;
    localparam logic [31:0] PC_STEP32       = 32'h0000_0004;
    localparam logic [31:0] WORD_STEP       = 32'h0000_0004;
    localparam logic [3:0]  CP_RSVD_LO      = 4'h8;
    localparam int unsigned NUM_CAUSE       = 5;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        OP_NOP     = 4'h0,
        OP_ADD     = 4'h1,
        OP_LOGIC   = 4'h2,
        OP_SIGNED_SATURATE_INSTR    = 4'h3,
        OP_UNSIGNED_SATURATE_INSTR    = 4'h4,
        OP_SVC     = 4'h5,
        OP_BREAKPOINT_INSTR    = 4'h6,
        OP_UNDEF   = 4'h7,
        OP_COPROC  = 4'h8,
        OP_BRANCH  = 4'h9,
        OP_MULTI   = 4'hA,
        OP_EXC_RET = 4'hB
    } sfma_op_e;

    typedef enum logic [2:0] {
        CAUSE_NONE   = 3'h0,
        CAUSE_SVC    = 3'h1,
        CAUSE_UNDEF  = 3'h2,
        CAUSE_NO_COPROCESSOR_CAUSE   = 3'h3,
        CAUSE_DBGMON = 3'h4,
        CAUSE_XN     = 3'h5
    } sfma_cause_e;

    typedef enum logic [0:0] {
        MODE_THREAD  = 1'b0,
        MODE_HANDLER = 1'b1
    } sfma_mode_e;

    typedef struct packed {
        logic        valid;
        sfma_op_e    op;
        logic        is32;
        logic        set_flags;
        logic        cin;
        logic [3:0]  cp_num;
        logic        cp_known;
        logic [4:0]  sat_n;
        logic [31:0] a;
        logic [31:0] b;
    } sfma_instr_s;

    typedef struct packed {
        logic        valid;
        sfma_cause_e cause;
    } sfma_exc_s;

endpackage
